// ### include/lgb_pkg.sv
// Shared constants and types for the logic array block
package lgb_pkg;
  localparam int NUM_CELLS = 8;
  localparam int NUM_CTRL  = 4;
  localparam int NUM_DED   = 4;
  localparam int NUM_PINS  = 4;
  localparam int NUM_ROUTE = 8;
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 32;
  localparam int LUT_W     = 16;
  localparam int CLK_LINES = 2;
  localparam int GLOB_AGE  = 3;

  // Register offsets; cell i has its function word at 2i, inputs at 2i+1
  localparam logic [4:0] REG_CELL_BASE = 5'h00;
  localparam logic [4:0] REG_CTRL_SRC  = 5'h10;
  localparam logic [4:0] REG_PIN_CFG   = 5'h11;
  localparam logic [4:0] REG_STATUS    = 5'h12;
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;

  // Cell function word
  localparam int LUT_LSB     = 0;
  localparam int FF_TYPE_LSB = 16;
  localparam int BYPASS_BIT  = 18;
  localparam int CLK_SEL_BIT = 19;
  localparam int CLR_SEL_LSB = 20;
  localparam int PRE_SEL_LSB = 22;
  localparam int CIN_SEL_BIT = 24;
  localparam int CASC_EN_BIT = 25;
  localparam int CASC_OR_BIT = 26;

  // Cell input word: one source index per look-up input
  localparam int IN_SEL_W = 4;

  // Control line source byte
  localparam int CTRL_FIELD_W = 8;
  localparam int SRC_KIND_LSB = 0;
  localparam int SRC_IDX_LSB  = 2;

  // Pin cell byte
  localparam int PIN_FIELD_W   = 8;
  localparam int PIN_MODE_LSB  = 0;
  localparam int PIN_DRIVE_BIT = 2;
  localparam int PIN_SRC_LSB   = 3;

  typedef enum logic [1:0] {
    LGB_FF_D, LGB_FF_T, LGB_FF_JK, LGB_FF_SR
  } lgb_ff_t;
  typedef enum logic [1:0] {
    LGB_SRC_DED, LGB_SRC_PIN, LGB_SRC_CELL, LGB_SRC_ROUTE
  } lgb_src_t;
  typedef enum logic [1:0] {
    LGB_PIN_COMB, LGB_PIN_IN_REG, LGB_PIN_OUT_REG
  } lgb_pin_mode_t;
  typedef enum logic [1:0] {
    LGB_CP_NONE, LGB_CP_LINE2, LGB_CP_LINE3
  } lgb_cp_t;
endpackage

// ### logic/lgb_logic_cell.sv
// One logic cell: look-up table, chains and programmable flip-flop
`timescale 1ns/1ps
module lgb_logic_cell (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic [lgb_pkg::DATA_W-1:0]  func_cfg,
  input  wire logic [3:0]                  lut_in,
  input  wire logic                        carry_in,
  input  wire logic                        cascade_in,
  input  wire logic [1:0]                  clk_edge,
  input  wire logic [1:0]                  cp_line_n,
  output logic                             comb_out,
  output logic                             carry_out,
  output logic                             cascade_out,
  output logic                             q
);
  import lgb_pkg::*;

  logic [LUT_W-1:0] lut_bits;
  logic [3:0]       lut_addr;
  logic             lut_res;
  logic             chain_res;
  lgb_ff_t          ff_type;
  logic [1:0]       clr_sel;
  logic [1:0]       pre_sel;
  logic             clr_n;
  logic             pre_n;
  logic             tick;
  logic             k_in;
  logic             next_q;

  assign lut_bits = func_cfg[LUT_LSB +: LUT_W];
  assign ff_type  = lgb_ff_t'(func_cfg[FF_TYPE_LSB +: 2]);
  assign clr_sel  = func_cfg[CLR_SEL_LSB +: 2];
  assign pre_sel  = func_cfg[PRE_SEL_LSB +: 2];
  // Carry-in may stand in for the fourth data input
  assign lut_addr = {func_cfg[CIN_SEL_BIT] ? carry_in : lut_in[3],
                     lut_in[2:0]};
  assign lut_res  = lut_bits[lut_addr];
  assign carry_out = (lut_in[0] & lut_in[1]) |
                     (carry_in & (lut_in[0] ^ lut_in[1]));
  assign chain_res = func_cfg[CASC_OR_BIT] ? (lut_res | cascade_in)
                                           : (lut_res & cascade_in);
  assign cascade_out = func_cfg[CASC_EN_BIT] ? chain_res : lut_res;
  // Unused clear or preset reads as inactive high
  assign clr_n = (clr_sel == LGB_CP_LINE2) ? cp_line_n[0] :
                 (clr_sel == LGB_CP_LINE3) ? cp_line_n[1] : 1'b1;
  assign pre_n = (pre_sel == LGB_CP_LINE2) ? cp_line_n[0] :
                 (pre_sel == LGB_CP_LINE3) ? cp_line_n[1] : 1'b1;
  assign tick  = clk_edge[func_cfg[CLK_SEL_BIT]];
  assign k_in  = lut_in[2];

  always_comb begin
    next_q = q;
    if (!clr_n) begin
      next_q = 1'b0;
    end else if (!pre_n) begin
      next_q = 1'b1;
    end else if (tick) begin
      case (ff_type)
        LGB_FF_D:  next_q = cascade_out;
        LGB_FF_T:  next_q = q ^ cascade_out;
        LGB_FF_JK: next_q = (cascade_out & ~q) | (~k_in & q);
        LGB_FF_SR: next_q = cascade_out ? 1'b1 : (k_in ? 1'b0 : q);
        default:   next_q = q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // Bypass hands the combinational result straight out
  assign comb_out = func_cfg[BYPASS_BIT] ? cascade_out : q;

  property p_clear;
    @(posedge ref_clk) disable iff (!reset_n)
      !clr_n |=> (q == 1'b0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed");

  property p_preset;
    @(posedge ref_clk) disable iff (!reset_n)
      (clr_n && !pre_n) |=> (q == 1'b1);
  endproperty
  a_preset: assert property (p_preset) else $error("preset missed");

  property p_toggle;
    @(posedge ref_clk) disable iff (!reset_n)
      (clr_n && pre_n && tick && ff_type == LGB_FF_T && cascade_out)
      |=> (q != $past(q));
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      (clr_n && pre_n && !tick) |=> $stable(q);
  endproperty
  a_hold: assert property (p_hold) else $error("moved w/o edge");

  property p_bypass;
    @(posedge ref_clk) disable iff (!reset_n)
      (func_cfg[BYPASS_BIT] && !func_cfg[CASC_EN_BIT])
      |-> (comb_out == lut_bits[lut_addr]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
endmodule

// ### logic/lgb_logic_array_block.sv
// Logic array block: eight cells, control lines, pin cells, config port
//
// How it works
// - Eight cells share one local interconnect and block control lines.
// - Each cell has a sixteen-entry table for any four-input function.
// - Cell flip-flop acts as D, toggle, JK or set-reset per config.
// - Bypass sends the table or cascade result straight to the cell output.
// - Four block control lines: two clocks, two clear or preset.
// - Each line picks a dedicated input, a pin or an internal signal.
// - Four low-skew global controls are taken from the dedicated inputs.
// - Logic from other blocks reaches the control lines via routing.
// - Carry and cascade chains run cell to cell and block to block.
// - Each pin cell has two-way buffer and flop for input or output.
// - Clear and preset are active low; unused ones held high.
// - Carry-in feeds the cell table and the next carry stage.
`timescale 1ns/1ps
module lgb_logic_array_block #(
  parameter int NUM_PINS = 4
) (
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  input  wire logic [lgb_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic [lgb_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                            reg_write,
  input  wire logic                            reg_read,
  output logic      [lgb_pkg::DATA_W-1:0]      reg_rdata,
  input  wire logic [lgb_pkg::NUM_DED-1:0]     ded_in,
  input  wire logic [lgb_pkg::NUM_ROUTE-1:0]   route_in,
  input  wire logic                            carry_in,
  input  wire logic                            cascade_in,
  input  wire logic [NUM_PINS-1:0]             pin_in,
  output logic      [NUM_PINS-1:0]             pin_out,
  output logic      [NUM_PINS-1:0]             pin_oe_n,
  output logic      [lgb_pkg::NUM_CELLS-1:0]   cell_out,
  output logic                                 carry_out,
  output logic                                 cascade_out,
  output logic      [lgb_pkg::NUM_DED-1:0]     global_ctrl
);
  import lgb_pkg::*;

  localparam int SRC_N = NUM_ROUTE + NUM_CELLS;

  // Configuration storage
  logic [DATA_W-1:0]    cfg_func [NUM_CELLS];
  logic [DATA_W-1:0]    cfg_in   [NUM_CELLS];
  logic [DATA_W-1:0]    ctrl_src;
  logic [DATA_W-1:0]    pin_cfg;

  // Synchronised pins and dedicated inputs
  logic [NUM_DED-1:0]   ded_s1;
  logic [NUM_DED-1:0]   ded_s2;
  logic [NUM_PINS-1:0]  pin_s1;
  logic [NUM_PINS-1:0]  pin_s2;

  // Internal nets
  logic [NUM_CELLS-1:0] cell_comb;
  logic [NUM_CELLS:0]   carry_chain;
  logic [NUM_CELLS:0]   cascade_chain;
  logic [SRC_N-1:0]     local_src;
  logic [NUM_CTRL-1:0]  line_val;
  logic [NUM_CTRL-1:0]  line_prev;
  logic [CLK_LINES-1:0] clk_edge;
  logic [1:0]           cp_line_n;
  logic [NUM_PINS-1:0]  pin_val;
  logic [NUM_PINS-1:0]  pin_q;
  logic                 cell_hit;
  logic [2:0]           cell_idx;
  logic [DATA_W-1:0]    status_word;
  logic [DATA_W-1:0]    rd_word;
  logic                 ctrl_we;
  logic                 pin_we;
  logic [1:0]           glob_age;

  // Register port decode
  assign cell_hit = reg_addr < REG_CTRL_SRC;
  assign cell_idx = reg_addr[3:1];
  assign ctrl_we  = reg_write && (reg_addr == REG_CTRL_SRC);
  assign pin_we   = reg_write && (reg_addr == REG_PIN_CFG);

  // Pins and dedicated inputs come from outside: two flops each
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ded_s1 <= '0;
      ded_s2 <= '0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      ded_s1 <= ded_in;
      ded_s2 <= ded_s1;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // Device-wide low-skew controls fan out from the dedicated inputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      global_ctrl <= '0;
    end else begin
      global_ctrl <= ded_s2;
    end
  end

  // Shared configuration words change only on a write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_src <= CFG_RESET;
      pin_cfg  <= CFG_RESET;
    end else begin
      if (ctrl_we) begin
        ctrl_src <= reg_wdata;
      end
      if (pin_we) begin
        pin_cfg <= reg_wdata;
      end
    end
  end

  // Local interconnect: routed signals first, then the cells' own outputs
  assign local_src = {cell_comb, route_in};

  assign carry_chain[0]   = carry_in;
  assign cascade_chain[0] = cascade_in;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
      logic       wr_func;
      logic       wr_in;
      logic [3:0] lut_in;
      genvar      gk;

      assign wr_func = reg_write && cell_hit && !reg_addr[0] &&
                       (cell_idx == 3'(gi));
      assign wr_in   = reg_write && cell_hit && reg_addr[0] &&
                       (cell_idx == 3'(gi));

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          cfg_func[gi] <= CFG_RESET;
          cfg_in[gi]   <= CFG_RESET;
        end else begin
          if (wr_func) begin
            cfg_func[gi] <= reg_wdata;
          end
          if (wr_in) begin
            cfg_in[gi] <= reg_wdata;
          end
        end
      end

      for (gk = 0; gk < 4; gk++) begin : g_in
        assign lut_in[gk] =
          local_src[cfg_in[gi][gk*IN_SEL_W +: IN_SEL_W]];
      end

      lgb_logic_cell u_cell (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .func_cfg    (cfg_func[gi]),
        .lut_in      (lut_in),
        .carry_in    (carry_chain[gi]),
        .cascade_in  (cascade_chain[gi]),
        .clk_edge    (clk_edge),
        .cp_line_n   (cp_line_n),
        .comb_out    (cell_comb[gi]),
        .carry_out   (carry_chain[gi+1]),
        .cascade_out (cascade_chain[gi+1]),
        .q           ()
      );
    end
  endgenerate

  // Block control lines: each picks its own source
  generate
    for (gi = 0; gi < NUM_CTRL; gi++) begin : g_line
      logic [1:0] kind;
      logic [2:0] idx;

      assign kind = ctrl_src[gi*CTRL_FIELD_W + SRC_KIND_LSB +: 2];
      assign idx  = ctrl_src[gi*CTRL_FIELD_W + SRC_IDX_LSB +: 3];
      assign line_val[gi] =
        (kind == LGB_SRC_DED)  ? ded_s2[idx[1:0]] :
        (kind == LGB_SRC_PIN)  ? pin_val[idx[1:0] % NUM_PINS] :
        (kind == LGB_SRC_CELL) ? cell_comb[idx] :
                                 route_in[idx];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_prev <= '0;
    end else begin
      line_prev <= line_val;
    end
  end

  // Lines 0 and 1 clock the cells on their rising edge
  assign clk_edge  = line_val[CLK_LINES-1:0] &
                     ~line_prev[CLK_LINES-1:0];
  // Lines 2 and 3 are the shared active-low clear/preset
  assign cp_line_n = line_val[NUM_CTRL-1:CLK_LINES];

  // Pin cells: one flop, used for capture or for drive
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic [1:0] mode;
      logic       drive;
      logic [2:0] src;
      logic       out_bit;

      assign mode  = pin_cfg[gi*PIN_FIELD_W + PIN_MODE_LSB +: 2];
      assign drive = pin_cfg[gi*PIN_FIELD_W + PIN_DRIVE_BIT];
      assign src   = pin_cfg[gi*PIN_FIELD_W + PIN_SRC_LSB +: 3];
      assign out_bit = cell_comb[src];
      assign pin_val[gi] = (mode == LGB_PIN_IN_REG) ? pin_q[gi]
                                                    : pin_s2[gi];

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_q[gi]    <= 1'b0;
          pin_out[gi]  <= 1'b0;
          pin_oe_n[gi] <= 1'b1;
        end else begin
          pin_q[gi]    <= (mode == LGB_PIN_IN_REG) ? pin_s2[gi]
                                                   : out_bit;
          pin_out[gi]  <= (mode == LGB_PIN_OUT_REG) ? pin_q[gi]
                                                    : out_bit;
          pin_oe_n[gi] <= !(drive && mode != LGB_PIN_IN_REG);
        end
      end
    end
  endgenerate

  // Block outputs toward routing and the next block in the row
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_out    <= '0;
      carry_out   <= 1'b0;
      cascade_out <= 1'b0;
    end else begin
      cell_out    <= cell_comb;
      carry_out   <= carry_chain[NUM_CELLS];
      cascade_out <= cascade_chain[NUM_CELLS];
    end
  end

  // Read side
  assign status_word = {14'h0000, cascade_chain[NUM_CELLS],
                        carry_chain[NUM_CELLS],
                        4'(pin_val), line_val, cell_comb};
  assign rd_word =
    cell_hit ? (reg_addr[0] ? cfg_in[cell_idx] : cfg_func[cell_idx]) :
    (reg_addr == REG_CTRL_SRC) ? ctrl_src :
    (reg_addr == REG_PIN_CFG)  ? pin_cfg :
    (reg_addr == REG_STATUS)   ? status_word : '0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_read ? rd_word : '0;
    end
  end

  // Helper: cycles since reset release, saturating
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      glob_age <= '0;
    end else if (glob_age != 2'(GLOB_AGE)) begin
      glob_age <= glob_age + 2'h1;
    end
  end

  property p_ctrl_static;
    @(posedge ref_clk) disable iff (!reset_n)
      !ctrl_we |=> $stable(ctrl_src);
  endproperty
  a_ctrl_static: assert property (p_ctrl_static)
    else $error("control select moved");

  property p_global;
    @(posedge ref_clk) disable iff (!reset_n)
      (glob_age == 2'(GLOB_AGE)) |-> (global_ctrl == $past(ded_in, 3));
  endproperty
  a_global: assert property (p_global)
    else $error("global control lag wrong");

  property p_pin_input;
    @(posedge ref_clk) disable iff (!reset_n)
      (g_pin[1].mode == LGB_PIN_IN_REG) |=> pin_oe_n[1];
  endproperty
  a_pin_input: assert property (p_pin_input)
    else $error("input pin driven");

  property p_pin_outreg;
    @(posedge ref_clk) disable iff (!reset_n)
      (g_pin[0].mode == LGB_PIN_OUT_REG)[*2]
      |=> (pin_out[0] == $past(g_pin[0].out_bit, 2));
  endproperty
  a_pin_outreg: assert property (p_pin_outreg)
    else $error("output register lag wrong");

  property p_rd_unmapped;
    @(posedge ref_clk) disable iff (!reset_n)
      (reg_read && reg_addr > REG_STATUS) |=> (reg_rdata == '0);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
endmodule

// ### sim/lgb_fabric_model.sv
// Far-side model: pads around the pin cells of the block
`timescale 1ns/1ps
module lgb_fabric_model (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  input  wire logic [3:0] ext_drv,
  input  wire logic [3:0] ext_en,
  output logic      [3:0] pin_in
);
  // Pad level: block drive when enabled, else outside driver, else pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_drv[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule

// ### sim/lgb_logic_array_block_tb.sv
// Self-checking bench for the logic array block
`timescale 1ns/1ps
module lgb_logic_array_block_tb;
  import lgb_pkg::*;
  logic                 ref_clk;
  logic                 reset_n;
  logic [ADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]    reg_wdata;
  logic                 reg_write;
  logic                 reg_read;
  logic [DATA_W-1:0]    reg_rdata;
  logic [NUM_DED-1:0]   ded_in;
  logic [NUM_ROUTE-1:0] route_in;
  logic                 carry_in;
  logic                 cascade_in;
  logic [3:0]           pin_in;
  logic [3:0]           pin_out;
  logic [3:0]           pin_oe_n;
  logic [3:0]           ext_drv;
  logic [3:0]           ext_en;
  logic [NUM_CELLS-1:0] cell_out;
  logic                 carry_out;
  logic                 cascade_out;
  logic [NUM_DED-1:0]   global_ctrl;
  int                   error_cnt = 0;
  int                   samples_checked = 0;
  int                   cyc = 0;
  logic [31:0]          rd;
  logic                 q_exp;
  logic                 c;
  logic [7:0]           src [4] = '{8'h04, 8'h05, 8'h02, 8'h1f};
  logic [1:0]           jk [6] = '{2'b10, 2'b11, 2'b01, 2'b11, 2'b00, 2'b10};
  logic [7:0]           rt [6] = '{8'h20, 8'h00, 8'h60, 8'h20, 8'h40, 8'h20};
  logic [5:0]           rq = 6'b101001;

  lgb_logic_array_block #(.NUM_PINS(4)) lgb_logic_array_block_inst (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .ded_in, .route_in, .carry_in, .cascade_in, .pin_in,
    .pin_out, .pin_oe_n, .cell_out, .carry_out, .cascade_out, .global_ctrl
  );
  lgb_fabric_model lgb_fabric_model_inst (
    .pin_out, .pin_oe_n, .ext_drv, .ext_en, .pin_in
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rdreg(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic settle();
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  task automatic drive(input logic [7:0] r, input logic ci, input logic ca);
    @(posedge ref_clk);
    route_in   <= r;
    carry_in   <= ci;
    cascade_in <= ca;
    settle();
  endtask

  // Cell 0 gets its own words, cells 1..7 share the others
  task automatic cfg(input logic [31:0] f0, fn, i0, in);
    wr(5'h00, f0);
    wr(5'h01, i0);
    for (int k = 1; k < 8; k++) begin
      wr(5'(2 * k), fn);
      wr(5'(2 * k + 1), in);
    end
  endtask

  function automatic logic [31:0] pat(input int a);
    logic [31:0] m;
    m = (a == 16) ? 32'h1f1f_1f1f : (a == 17) ? 32'h3f3f_3f3f :
        a[0] ? 32'h0000_ffff : 32'h07ff_ffff;
    pat = (32'h5a5a_5a5a ^ (32'(a) * 32'h0102_0408)) & m;
  endfunction

  function automatic logic nq(input int t, input logic q, j, k);
    case (t)
      0: nq = j;
      1: nq = q ^ j;
      2: nq = (j & k) ? ~q : (j ? 1'b1 : (k ? 1'b0 : q));
      default: nq = j ? 1'b1 : (k ? 1'b0 : q);
    endcase
  endfunction

  function automatic logic maj(input logic a, b, d);
    maj = (a & b) | (a & d) | (b & d);
  endfunction

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_write = 1'b0;
    reg_read = 1'b0; ded_in = '0; route_in = 8'h60; carry_in = 1'b0;
    cascade_in = 1'b0; ext_drv = 4'h0; ext_en = 4'h0; q_exp = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk("oe_n at reset", 32'(pin_oe_n), 32'hf);
    chk("cells at reset", 32'(cell_out), 32'h0);
    for (int a = 0; a < 18; a++) begin
      rdreg(5'(a), rd);
      chk("reset reg", rd, CFG_RESET);
      wr(5'(a), pat(a));
    end
    for (int a = 0; a < 18; a++) begin
      rdreg(5'(a), rd);
      chk("readback", rd, pat(a));
    end
    rdreg(5'h13, rd);
    chk("unmapped 13", rd, 32'h0);
    rdreg(5'h1f, rd);
    chk("unmapped 1f", rd, 32'h0);
    // Mid-run reset clears flop state left by the readback patterns
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk("oe_n after reset", 32'(pin_oe_n), 32'hf);
    chk("cells after reset", 32'(cell_out), 32'h0);
    rdreg(REG_PIN_CFG, rd);
    chk("pin cfg after reset", rd, CFG_RESET);
    wr(REG_PIN_CFG, 32'h0);
    cfg(32'h0004_aaaa, 32'h0, 32'h0, 32'h0);
    @(posedge ref_clk);
    ded_in  <= 4'b0010;
    ext_drv <= 4'b0101;
    ext_en  <= 4'hf;
    drive(8'hf0, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL_SRC, {16'h0, src[k], 8'h00});
      settle();
      rdreg(REG_STATUS, rd);
      chk("line1", 32'(rd[9]), 32'(k == 0 || k == 3));
    end
    chk("pin values", 32'(rd[15:12]), 32'h5);
    chk("global", 32'(global_ctrl), 32'h2);
    cfg(32'h0004_c6a1, 32'h0, 32'h0000_3210, 32'h0);
    for (int v = 0; v < 16; v++) begin
      drive({4'h6, 4'(v)}, 1'b0, 1'b0);
      chk("table", 32'(cell_out[0]), 32'(16'hc6a1 >> v) & 1);
      chk("other cells", 32'(cell_out[7:1]), 32'h0);
    end
    wr(REG_CTRL_SRC, 32'h1b17_0013);
    drive(8'h60, 1'b0, 1'b0);
    for (int t = 0; t < 4; t++) begin
      wr(REG_CELL_BASE, {14'h0, 2'(t), 16'haaaa});
      for (int s = 0; s < 6; s++) begin
        drive({5'h0c, jk[s][0], 1'b0, jk[s][1]}, 1'b0, 1'b0);
        if (t + s > 0) chk("hold", 32'(cell_out[0]), 32'(q_exp));
        @(posedge ref_clk);
        route_in[4] <= 1'b1;
        @(posedge ref_clk);
        route_in[4] <= 1'b0;
        settle();
        q_exp = nq(t, q_exp, jk[s][1], jk[s][0]);
        chk("flop", 32'(cell_out[0]), 32'(q_exp));
      end
    end
    wr(REG_CELL_BASE, 32'h0090_aaaa);
    for (int s = 0; s < 6; s++) begin
      drive(rt[s], 1'b0, 1'b0);
      chk("clear preset", 32'(cell_out[0]), 32'(rq[s]));
    end
    wr(REG_CELL_BASE, 32'h0000_aaaa);
    drive(8'h00, 1'b0, 1'b0);
    chk("unused clear", 32'(cell_out[0]), 32'h1);
    cfg(32'h0104_ff00, 32'h0004_0000, 32'h0000_0010, 32'h0000_0032);
    for (int v = 0; v < 32; v++) begin
      drive({4'h6, 4'(v)}, v[4], 1'b0);
      c = maj(v[2], v[3], maj(v[0], v[1], v[4]));
      chk("carry out", 32'(carry_out), 32'(c));
      chk("carry to table", 32'(cell_out[0]), 32'(v[4]));
    end
    for (int m = 0; m < 2; m++) begin
      cfg({5'h0, 1'(m), 26'h204_aaaa}, {5'h0, 1'(m), 26'h204_aaaa}, 0, 0);
      for (int v = 0; v < 4; v++) begin
        drive({7'h30, v[0]}, 1'b0, v[1]);
        c = m ? (v[0] | v[1]) : (v[0] & v[1]);
        chk("cascade", 32'(cascade_out), 32'(c));
      end
    end
    cfg(32'h0004_aaaa, 32'h0, 32'h0, 32'h0);
    @(posedge ref_clk);
    ext_en <= 4'b1010;
    wr(REG_PIN_CFG, 32'h0006_0504);
    for (int v = 0; v < 2; v++) begin
      drive({7'h30, v[0]}, 1'b0, 1'b0);
      chk("pin oe_n", 32'(pin_oe_n), 32'ha);
      chk("pin0 out", 32'(pin_out[0]), 32'(v[0]));
      chk("pin2 out", 32'(pin_out[2]), 32'(v[0]));
    end
    finish_test();
  end
endmodule
